// >>> common/plut_pkg.sv
// Constants, register map and types of the pixel lookup-table mapper.
// Assumes one 25 MHz pixel clock and a synchronous active-high reset.
// What this block does
// [R01] Each pixel is looked up by an 11-bit address and yields 9 bits.
// [R02] Pixel values above 2047 are looked up as 2047.
// [R03] The mapping works for every output pixel format.
// [R04] 8-bit formats take the mapped value with its lowest bit dropped.
// [R05] 12-bit formats put the value on top and zero the low 3 bits.
// [R06] 16-bit formats put the value on top and zero the low 7 bits.
// [R07] After reset the table is reloaded with output equal to input over four.
// [R08] Only one table exists; the selector has exactly one choice.
// [R09] Coefficient writes act at once, even while the table is enabled.
// [R10] Software should disable the table while it changes coefficients.
// [R11] An index picks the coefficient that value reads and writes reach.
// [R12] A bulk port walks all coefficients without using the index.
// [R13] Colour formats send all three channels through the same table.
// [R14] Mono and Bayer formats use one channel through the same table.
// [R15] Coefficients are volatile and return to the default after reset.
// [R16] A disabled table passes the saturated pixel over four to alignment.
// [R17] 2048 entries of 9 bits; mapped output registered one clock after input.
package plut_pkg;
    localparam int PLUT_AW          = 8;
    localparam int PLUT_DW          = 32;
    localparam int PLUT_IN_W        = 12;
    localparam int PLUT_IDX_W       = 11;
    localparam int PLUT_MAP_W       = 9;
    localparam int PLUT_OUT_W       = 16;
    localparam int PLUT_DEPTH       = 2048;
    localparam int PLUT_LANES       = 3;

    localparam logic [7:0] PLUT_REG_CTRL     = 8'h00;
    localparam logic [7:0] PLUT_REG_SELECT   = 8'h04;
    localparam logic [7:0] PLUT_REG_INDEX    = 8'h08;
    localparam logic [7:0] PLUT_REG_VALUE    = 8'h0C;
    localparam logic [7:0] PLUT_REG_BULK     = 8'h10;
    localparam logic [7:0] PLUT_REG_BULK_PTR = 8'h14;
    localparam logic [7:0] PLUT_REG_STATUS   = 8'h18;

    localparam int PLUT_CTRL_ENABLE = 0;
    localparam int PLUT_CTRL_FMT_LO = 1;
    localparam int PLUT_CTRL_COLOUR = 3;

    localparam logic [11:0] PLUT_SAT_MAX     = 12'h7FF;
    localparam logic        PLUT_ENABLE_RST  = 1'b0;
    localparam logic        PLUT_COLOUR_RST  = 1'b0;
    localparam logic [10:0] PLUT_INDEX_RST   = 11'h000;
    localparam logic [10:0] PLUT_LAST_INDEX  = 11'h7FF;
    localparam logic [31:0] PLUT_SELECT_ONLY = 32'h0000_0000;

    typedef enum logic [1:0] {
        PLUT_FMT_8  = 2'b00,
        PLUT_FMT_12 = 2'b01,
        PLUT_FMT_16 = 2'b10
    } plut_fmt_t;

    localparam plut_fmt_t PLUT_FMT_RST = PLUT_FMT_8;

    typedef enum logic {
        PLUT_ST_LOAD = 1'b0,
        PLUT_ST_RUN  = 1'b1
    } plut_state_t;
endpackage

// >>> hdl/plut_mapper.sv
// Pixel lookup-table mapper: three lanes through one 2048x9 table, then format alignment.
// Assumes a register master with one-cycle strobes and a pixel source/sink using valid/ready.
//
// Chosen here: the address map and strobed register access.
module plut_mapper (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [11:0] in_pixel0,
    input  wire logic [11:0] in_pixel1,
    input  wire logic [11:0] in_pixel2,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic      [15:0] out_pixel0,
    output logic      [15:0] out_pixel1,
    output logic      [15:0] out_pixel2
);
    logic [8:0]              table_mem [plut_pkg::PLUT_DEPTH];
    plut_pkg::plut_state_t   state;
    logic [10:0]             load_ptr;
    logic                    table_enable;
    logic                    colour_mode;
    plut_pkg::plut_fmt_t     out_fmt;
    logic [10:0]             coefficient_index;
    logic [10:0]             bulk_ptr;
    logic [47:0]             spare;
    logic                    spare_valid;

    wire load_busy = (state == plut_pkg::PLUT_ST_LOAD);

    // Register decode
    wire sel_ctrl  = (reg_addr == plut_pkg::PLUT_REG_CTRL);
    wire sel_sel   = (reg_addr == plut_pkg::PLUT_REG_SELECT);
    wire sel_index = (reg_addr == plut_pkg::PLUT_REG_INDEX);
    wire sel_value = (reg_addr == plut_pkg::PLUT_REG_VALUE);
    wire sel_bulk  = (reg_addr == plut_pkg::PLUT_REG_BULK);
    wire sel_bptr  = (reg_addr == plut_pkg::PLUT_REG_BULK_PTR);
    wire sel_stat  = (reg_addr == plut_pkg::PLUT_REG_STATUS);

    wire val_wr  = reg_wr && sel_value && !load_busy;
    wire bulk_wr = reg_wr && sel_bulk && !load_busy;
    wire bulk_rd = reg_rd && sel_bulk;
    wire [1:0] wr_fmt = reg_wdata[plut_pkg::PLUT_CTRL_FMT_LO +: 2];
    wire fmt_legal = (wr_fmt != 2'b11);

    // Table write port: reload after reset wins, then indexed, then bulk
    wire        mem_we    = load_busy || val_wr || bulk_wr;
    wire [10:0] mem_waddr = load_busy ? load_ptr
                          : (val_wr ? coefficient_index : bulk_ptr);
    wire [8:0]  mem_wdata = load_busy ? load_ptr[10:2] : reg_wdata[8:0];

    always_ff @(posedge clk)
    begin
        if (mem_we)
            table_mem[mem_waddr] <= mem_wdata; // [R09] [R11] [R12]
    end

    // Default reload after every reset: a power cycle loses all user contents
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state    <= plut_pkg::PLUT_ST_LOAD; // [R15]
            load_ptr <= plut_pkg::PLUT_INDEX_RST;
        end
        else
        begin
            case (state)
                plut_pkg::PLUT_ST_LOAD:
                begin
                    load_ptr <= load_ptr + 11'h001; // [R07]
                    if (load_ptr == plut_pkg::PLUT_LAST_INDEX)
                        state <= plut_pkg::PLUT_ST_RUN;
                end
                plut_pkg::PLUT_ST_RUN:
                    state <= plut_pkg::PLUT_ST_RUN;
                default:
                    state <= plut_pkg::PLUT_ST_LOAD;
            endcase
        end
    end

    // Control registers; the bulk pointer steps on every bulk read and on every bulk write outside the reload
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            table_enable      <= plut_pkg::PLUT_ENABLE_RST;
            colour_mode       <= plut_pkg::PLUT_COLOUR_RST;
            out_fmt           <= plut_pkg::PLUT_FMT_RST;
            coefficient_index <= plut_pkg::PLUT_INDEX_RST;
            bulk_ptr          <= plut_pkg::PLUT_INDEX_RST;
        end
        else
        begin
            if (reg_wr && sel_ctrl)
            begin
                table_enable <= reg_wdata[plut_pkg::PLUT_CTRL_ENABLE];
                colour_mode  <= reg_wdata[plut_pkg::PLUT_CTRL_COLOUR];
                if (fmt_legal)
                    out_fmt <= plut_pkg::plut_fmt_t'(wr_fmt); // [R03]
            end
            if (reg_wr && sel_index)
                coefficient_index <= reg_wdata[10:0]; // [R11]
            if (reg_wr && sel_bptr)
                bulk_ptr <= reg_wdata[10:0];
            else if (bulk_wr || bulk_rd)
                bulk_ptr <= bulk_ptr + 11'h001; // [R12]
        end
    end

    // Read mux; the selector only ever holds its single choice
    wire [31:0] rd_ctrl = {28'h0000000, colour_mode, out_fmt, table_enable};
    wire [31:0] rd_stat = {29'h00000000, spare_valid, out_valid, load_busy};
    wire [31:0] rd_mux =
        sel_ctrl  ? rd_ctrl :
        sel_sel   ? plut_pkg::PLUT_SELECT_ONLY : // [R08]
        sel_index ? {21'h000000, coefficient_index} :
        sel_value ? {23'h000000, table_mem[coefficient_index]} : // [R11]
        sel_bulk  ? {23'h000000, table_mem[bulk_ptr]} : // [R12]
        sel_bptr  ? {21'h000000, bulk_ptr} :
        sel_stat  ? rd_stat : 32'h00000000;

    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end

    // Per-lane saturate, lookup and alignment
    logic [11:0] lane_in  [plut_pkg::PLUT_LANES];
    logic [10:0] lane_adr [plut_pkg::PLUT_LANES];
    logic [8:0]  lane_map [plut_pkg::PLUT_LANES];
    logic [15:0] lane_out [plut_pkg::PLUT_LANES];
    assign lane_in[0] = in_pixel0;
    assign lane_in[1] = in_pixel1;
    assign lane_in[2] = in_pixel2;

    genvar g;
    generate
        for (g = 0; g < plut_pkg::PLUT_LANES; g++)
        begin : g_lane
            wire        over = lane_in[g] > plut_pkg::PLUT_SAT_MAX;
            wire [10:0] sat  = over ? plut_pkg::PLUT_SAT_MAX[10:0]
                                    : lane_in[g][10:0]; // [R02]
            // Mono and Bayer carry one channel; the spare lanes output zero
            wire        live = (g == 0) || colour_mode; // [R13] [R14]
            assign lane_adr[g] = sat; // [R01]
            assign lane_map[g] = !live ? 9'h000
                               : (table_enable ? table_mem[sat] : sat[10:2]); // [R16]
            assign lane_out[g] =
                (out_fmt == plut_pkg::PLUT_FMT_12) ? {4'h0, lane_map[g], 3'h0} : // [R05]
                (out_fmt == plut_pkg::PLUT_FMT_16) ? {lane_map[g], 7'h00} : // [R06]
                {8'h00, lane_map[g][8:1]}; // [R04]
        end
    endgenerate

    wire [47:0] mapped = {lane_out[2], lane_out[1], lane_out[0]};

    // Two-entry buffer: head drives the outputs, spare absorbs one stalled word
    wire push = in_valid && in_ready;
    wire head_free = !out_valid || out_ready;
    wire        next_out_valid = head_free ? (spare_valid || push) : 1'b1;
    wire [47:0] next_head = !head_free ? {out_pixel2, out_pixel1, out_pixel0}
                          : (spare_valid ? spare : mapped);
    wire        next_spare_valid = !head_free && (spare_valid || push);
    wire [47:0] next_spare = (!head_free && push) ? mapped : spare;
    wire        next_in_ready = !next_spare_valid && (state == plut_pkg::PLUT_ST_RUN);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_valid   <= 1'b0;
            spare_valid <= 1'b0;
            in_ready    <= 1'b0;
            spare       <= 48'h000000000000;
            {out_pixel2, out_pixel1, out_pixel0} <= 48'h000000000000;
        end
        else
        begin
            out_valid   <= next_out_valid; // [R17]
            spare_valid <= next_spare_valid;
            in_ready    <= next_in_ready;
            spare       <= next_spare;
            {out_pixel2, out_pixel1, out_pixel0} <= next_head; // [R17]
        end
    end

    // Checks
    sequence s_val_write;
        reg_wr && sel_value && !load_busy;
    endsequence

    sequence s_val_read;
        reg_rd && sel_value && !reg_wr;
    endsequence

    sequence s_direct_push;
        push && head_free && !spare_valid;
    endsequence

    chk_map_latency: assert property ( // [R17] [R01]
        @(posedge clk) disable iff (rst)
        s_direct_push |=> out_valid && out_pixel0 == $past(lane_out[0]))
        else $error("mapped pixel not presented one clock after input");

    chk_saturate_addr: assert property ( // [R02]
        @(posedge clk) disable iff (rst)
        (in_pixel0 > 12'h7FF) |-> lane_adr[0] == 11'h7FF)
        else $error("oversized pixel not saturated to 2047");

    chk_fmt8_align: assert property ( // [R04]
        @(posedge clk) disable iff (rst)
        out_fmt == plut_pkg::PLUT_FMT_8 |-> lane_out[0] == {8'h00, lane_map[0][8:1]})
        else $error("8-bit alignment wrong");

    chk_fmt12_align: assert property ( // [R05]
        @(posedge clk) disable iff (rst)
        out_fmt == plut_pkg::PLUT_FMT_12 |-> lane_out[1][15:3] == {4'h0, lane_map[1]}
            && lane_out[1][2:0] == 3'h0)
        else $error("12-bit alignment wrong");

    chk_fmt16_align: assert property ( // [R06]
        @(posedge clk) disable iff (rst)
        out_fmt == plut_pkg::PLUT_FMT_16 |-> lane_out[2] == {lane_map[2], 7'h00})
        else $error("16-bit alignment wrong");

    chk_default_load: assert property ( // [R07] [R15]
        @(posedge clk) disable iff (rst)
        load_busy |-> mem_we && mem_wdata == mem_waddr[10:2] && !in_ready)
        else $error("default table not loaded as input over four");

    chk_load_done: assert property ( // [R07]
        @(posedge clk) disable iff (rst)
        load_busy && load_ptr == 11'h7FF |=> !load_busy ##1 in_ready || out_valid)
        else $error("reload did not finish after the last entry");

    chk_select_single: assert property ( // [R08]
        @(posedge clk) disable iff (rst)
        reg_rd && sel_sel |=> reg_rdata == 32'h00000000)
        else $error("selector shows a second table");

    chk_value_roundtrip: assert property ( // [R11] [R09]
        @(posedge clk) disable iff (rst)
        s_val_write ##1 s_val_read |=> reg_rdata[8:0] == $past(reg_wdata[8:0], 2))
        else $error("indexed coefficient read does not return the write");

    chk_bulk_step: assert property ( // [R12]
        @(posedge clk) disable iff (rst)
        (bulk_rd || bulk_wr) && !(reg_wr && sel_bptr) |=> bulk_ptr == $past(bulk_ptr) + 11'h001)
        else $error("bulk pointer did not advance");

    chk_bypass_map: assert property ( // [R16]
        @(posedge clk) disable iff (rst)
        !table_enable && push |-> lane_map[0] == lane_adr[0][10:2])
        else $error("disabled table still maps pixels");

    chk_lane_share: assert property ( // [R13] [R14]
        @(posedge clk) disable iff (rst)
        (colour_mode && in_pixel0 == in_pixel1 && in_pixel1 == in_pixel2)
            |-> lane_out[0] == lane_out[1] && lane_out[1] == lane_out[2])
        else $error("colour lanes not sharing one table");

    chk_mono_lanes: assert property ( // [R14]
        @(posedge clk) disable iff (rst)
        !colour_mode |-> lane_out[1] == 16'h0000 && lane_out[2] == 16'h0000)
        else $error("mono format drives spare lanes");

    chk_no_overrun: assert property ( // [R17]
        @(posedge clk) disable iff (rst)
        out_valid && !out_ready |=> out_valid && $stable(out_pixel0))
        else $error("stalled word changed or dropped");

    // The registered word, not only the lane logic, must show the alignment
    chk_fmt8_out: assert property ( // [R04]
        @(posedge clk) disable iff (rst)
        s_direct_push ##0 out_fmt == plut_pkg::PLUT_FMT_8 |=> out_pixel0[15:8] == 8'h00)
        else $error("8-bit pixel carries upper bits");

    chk_fmt12_out: assert property ( // [R05]
        @(posedge clk) disable iff (rst)
        s_direct_push ##0 out_fmt == plut_pkg::PLUT_FMT_12
            |=> out_pixel1[15:12] == 4'h0 && out_pixel1[2:0] == 3'h0)
        else $error("12-bit pixel top or low bits not zero");

    chk_fmt16_out: assert property ( // [R06]
        @(posedge clk) disable iff (rst)
        s_direct_push ##0 out_fmt == plut_pkg::PLUT_FMT_16 |=> out_pixel2[6:0] == 7'h00)
        else $error("16-bit pixel low bits not zero");

    chk_index_store: assert property ( // [R11] [R09]
        @(posedge clk) disable iff (rst)
        s_val_write |=> table_mem[$past(coefficient_index)] == $past(reg_wdata[8:0]))
        else $error("indexed write did not reach the table");

    chk_reload_entry: assert property ( // [R07]
        @(posedge clk) disable iff (rst)
        load_busy |=> table_mem[$past(load_ptr)] == $past(load_ptr[10:2]))
        else $error("reload entry is not index over four");

    chk_stall_spare: assert property ( // [R17]
        @(posedge clk) disable iff (rst)
        push && out_valid && !out_ready |=> spare_valid && !in_ready)
        else $error("word taken under stall not held in spare entry");

    chk_rdata_idle: assert property ( // [R11]
        @(posedge clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data shown without a read strobe");
endmodule

// >>> test/pixel_lookup_table_mapper_tb_top.sv
// Self-checking bench for the pixel lookup-table mapper.
// Assumes the bench drives both the register port and the pixel stream itself.
module pixel_lookup_table_mapper_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        in_valid  = 1'b0;
    logic        in_ready;
    logic [11:0] in_pixel0 = 12'h000;
    logic [11:0] in_pixel1 = 12'h000;
    logic [11:0] in_pixel2 = 12'h000;
    logic        out_valid;
    logic        out_ready = 1'b0;
    logic [15:0] out_pixel0;
    logic [15:0] out_pixel1;
    logic [15:0] out_pixel2;
    int          err_count = 0;
    int          checks    = 0;

    plut_mapper u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
        .in_ready(in_ready), .in_pixel0(in_pixel0), .in_pixel1(in_pixel1),
        .in_pixel2(in_pixel2), .out_valid(out_valid), .out_ready(out_ready),
        .out_pixel0(out_pixel0), .out_pixel1(out_pixel1), .out_pixel2(out_pixel2));

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Saturate, then the power-on linear entry
    function automatic logic [8:0] lin(input logic [11:0] p);
        lin = (p > 12'h7FF) ? 9'h1FF : p[10:2];
    endfunction

    function automatic logic [15:0] al(input logic [8:0] m, input logic [1:0] f);
        case (f)
            2'h0:    al = {8'h00, m[8:1]};
            2'h1:    al = {4'h0, m, 3'h0};
            default: al = {m, 7'h00};
        endcase
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), e, reg_rdata);
    endtask

    // Write, then read the same address in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), e, reg_rdata);
    endtask

    task automatic ctrl(input logic en, input logic [1:0] f, input logic col);
        wr(plut_pkg::PLUT_REG_CTRL, {28'h0000000, col, f, en});
    endtask

    task automatic push(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c);
        int n;
        @(posedge clk);
        in_valid  <= 1'b1;
        in_pixel0 <= a;
        in_pixel1 <= b;
        in_pixel2 <= c;
        n = 0;
        #1;
        while (in_ready !== 1'b1)
        begin
            n++;
            if (n > 2200)
            begin
                err_count++;
                $display("mismatch in_ready expected 1 seen %b", in_ready);
                final_report();
            end
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        in_valid <= 1'b0;
    endtask

    task automatic pop(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        int n;
        @(posedge clk);
        out_ready <= 1'b1;
        n = 0;
        #1;
        while (out_valid !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_count++;
                $display("mismatch out_valid expected 1 seen %b", out_valid);
                final_report();
            end
            @(posedge clk);
            #1;
        end
        check("lane0", {16'h0000, a}, {16'h0000, out_pixel0});
        check("lane1", {16'h0000, b}, {16'h0000, out_pixel1});
        check("lane2", {16'h0000, c}, {16'h0000, out_pixel2});
        @(posedge clk);
        out_ready <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        push(12'h000, 12'h000, 12'h000);
        pop(16'h0000, 16'h0000, 16'h0000);
    endtask

    task automatic t_regs();
        rdc(plut_pkg::PLUT_REG_CTRL, 32'h0000_0000);
        rdc(plut_pkg::PLUT_REG_SELECT, plut_pkg::PLUT_SELECT_ONLY);
        wr(plut_pkg::PLUT_REG_SELECT, 32'h0000_0001);
        rdc(plut_pkg::PLUT_REG_SELECT, plut_pkg::PLUT_SELECT_ONLY);
        ctrl(1'b1, 2'h3, 1'b0);
        rdc(plut_pkg::PLUT_REG_CTRL, 32'h0000_0001);
        rdc(8'h1C, 32'h0000_0000);
        $display("done registers");
    endtask

    task automatic t_default();
        logic [1:0] f;
        for (f = 2'h0; f != 2'h3; f++)
        begin
            ctrl(1'b1, f, 1'b1);
            push(12'h010, 12'h7FF, 12'hFFF);
            pop(al(lin(12'h010), f), al(lin(12'h7FF), f), al(lin(12'hFFF), f));
        end
        $display("done default table");
    endtask

    task automatic t_index();
        wr(plut_pkg::PLUT_REG_INDEX, 32'h0000_0005);
        wr_rd(plut_pkg::PLUT_REG_VALUE, 32'h0000_01AB, 32'h0000_01AB);
        wr(plut_pkg::PLUT_REG_INDEX, 32'h0000_07FF);
        rdc(plut_pkg::PLUT_REG_INDEX, 32'h0000_07FF);
        wr(plut_pkg::PLUT_REG_VALUE, 32'hFFFF_F155);
        rdc(plut_pkg::PLUT_REG_VALUE, 32'h0000_0155);
        ctrl(1'b1, 2'h2, 1'b1);
        push(12'h005, 12'hABC, 12'h7FF);
        pop(al(9'h1AB, 2'h2), al(9'h155, 2'h2), al(9'h155, 2'h2));
        ctrl(1'b1, 2'h2, 1'b0);
        push(12'hABC, 12'h005, 12'h005);
        pop(al(9'h155, 2'h2), 16'h0000, 16'h0000);
        $display("done index access");
    endtask

    task automatic t_bulk();
        ctrl(1'b0, 2'h2, 1'b0);
        wr(plut_pkg::PLUT_REG_BULK_PTR, 32'h0000_07FF);
        wr(plut_pkg::PLUT_REG_BULK, 32'h0000_00AA);
        wr(plut_pkg::PLUT_REG_BULK, 32'h0000_00BB);
        wr(plut_pkg::PLUT_REG_INDEX, 32'h0000_0000);
        rdc(plut_pkg::PLUT_REG_VALUE, 32'h0000_00BB);
        wr(plut_pkg::PLUT_REG_BULK_PTR, 32'h0000_07FF);
        rdc(plut_pkg::PLUT_REG_BULK, 32'h0000_00AA);
        rdc(plut_pkg::PLUT_REG_BULK, 32'h0000_00BB);
        rdc(plut_pkg::PLUT_REG_BULK_PTR, 32'h0000_0001);
        $display("done bulk access");
    endtask

    task automatic t_disable();
        ctrl(1'b0, 2'h1, 1'b1);
        push(12'h005, 12'hABC, 12'h000);
        pop(al(9'h001, 2'h1), al(9'h1FF, 2'h1), al(9'h000, 2'h1));
        $display("done disabled table");
    endtask

    // Sink stalls: two words fill both entries, a third must wait
    task automatic t_stall();
        ctrl(1'b1, 2'h0, 1'b1);
        push(12'h100, 12'h104, 12'h108);
        #1;
        check("out_valid", 32'h0000_0001, {31'h0, out_valid});
        push(12'h200, 12'h204, 12'h208);
        @(posedge clk);
        in_valid <= 1'b1;
        repeat (3)
        begin
            #1;
            check("in_ready", 32'h0000_0000, {31'h0, in_ready});
            @(posedge clk);
        end
        in_valid <= 1'b0;
        rdc(plut_pkg::PLUT_REG_STATUS, 32'h0000_0006);
        pop(al(9'h040, 2'h0), al(9'h041, 2'h0), al(9'h042, 2'h0));
        pop(al(9'h080, 2'h0), al(9'h081, 2'h0), al(9'h082, 2'h0));
        #1;
        check("out_valid", 32'h0000_0000, {31'h0, out_valid});
        $display("done stall");
    endtask

    task automatic t_power();
        do_reset();
        wr(plut_pkg::PLUT_REG_INDEX, 32'h0000_0005);
        rdc(plut_pkg::PLUT_REG_VALUE, 32'h0000_0001);
        ctrl(1'b1, 2'h2, 1'b0);
        push(12'hABC, 12'h000, 12'h000);
        pop(al(9'h1FF, 2'h2), 16'h0000, 16'h0000);
        $display("done second reset");
    endtask

    initial
    begin
        do_reset();
        t_regs();
        t_default();
        t_index();
        t_bulk();
        t_disable();
        t_stall();
        t_power();
        final_report();
    end
endmodule
